/* File: common/rott_pkg.sv */
/*
 * Constants, settings ranges, register map and curve table of the
 * residual overcurrent trip timer.
 * Assumes a 100 MHz clock and magnitudes given in percent of rated current.
 */
package rott_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 1;                       // Integrator tick, us
    localparam int US_CYC = TICK_US * (CLK_HZ / 1_000_000);
    localparam int MS_TICKS = 1000 / TICK_US;         // Ticks per ms

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] A_OPER = 8'h00;
    localparam logic [7:0] A_THR = 8'h04;
    localparam logic [7:0] A_TMS = 8'h08;
    localparam logic [7:0] A_MINDEL = 8'h0c;
    localparam logic [7:0] A_DEFDEL = 8'h10;
    localparam logic [7:0] A_RSTDEL = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_IRQ_ST = 8'h1c;
    localparam logic [7:0] A_IRQ_MASK = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // Setting ranges and reset values
    localparam logic [15:0] THR_MIN = 16'h0005;       // 5 %
    localparam logic [15:0] THR_MAX = 16'h03e8;       // 1000 %
    localparam logic [15:0] THR_RST = 16'h0032;       // 50 %
    localparam logic [15:0] TMS_MIN = 16'h0005;       // 0.05 in 0.01 steps
    localparam logic [15:0] TMS_MAX = 16'h05dc;       // 15.00
    localparam logic [15:0] TMS_RST = 16'h0064;       // 1.00
    localparam logic [15:0] DLY_MIN = 16'h0028;       // 40 ms
    localparam logic [15:0] RDLY_MIN = 16'h003c;      // 60 ms
    localparam logic [15:0] DLY_MAX = 16'hea60;       // 60000 ms
    localparam logic [15:0] DLY_RST = 16'h0064;       // 100 ms
    localparam logic [3:0] OP_OFF = 4'h0;
    localparam logic [3:0] OP_DEF = 4'h1;
    localparam logic [3:0] OP_LAST = 4'hc;
    localparam logic [15:0] GD_MULT = 16'h0014;       // Flat above 20 x start
    localparam logic [55:0] LOG_K = 56'h0000_0000_0048_22; // 1/(0.02*ln2/256)
    localparam int IRQ_START = 0;
    localparam int IRQ_TRIP = 1;

    // Curve exponent classes
    typedef enum logic [1:0] {
        ROTT_A_FRAC = 2'h0,
        ROTT_A_ONE = 2'h1,
        ROTT_A_TWO = 2'h2
    } rott_alpha_e;

    // Timer states, Gray along idle, run, offset, trip
    typedef enum logic [1:0] {
        ROTT_IDLE = 2'b00,
        ROTT_RUN = 2'b01,
        ROTT_OFFS = 2'b11,
        ROTT_TRIP = 2'b10
    } rott_state_e;

    // Curve constant kr in units of 100 us
    function automatic logic [20:0] rott_kr(input logic [3:0] op);
        case (op)
            4'h2: rott_kr = 21'h00_0578;
            4'h3: rott_kr = 21'h02_0f58;
            4'h4: rott_kr = 21'h0c_3500;
            4'h5: rott_kr = 21'h12_4f80;
            4'h6: rott_kr = 21'h00_0056;
            4'h7: rott_kr = 21'h00_0203;
            4'h8: rott_kr = 21'h02_fe04;
            4'h9: rott_kr = 21'h04_4d90;
            4'ha: rott_kr = 21'h00_035c;
            4'hb: rott_kr = 21'h04_5b3c;
            4'hc: rott_kr = 21'h09_c6bc;
            default: rott_kr = 21'h00_0000;
        endcase
    endfunction : rott_kr

    // Curve offset c in units of 100 us
    function automatic logic [12:0] rott_c(input logic [3:0] op);
        case (op)
            4'h6: rott_c = 13'h00b9;
            4'h7: rott_c = 13'h0474;
            4'h8: rott_c = 13'h132e;
            4'h9: rott_c = 13'h04c1;
            4'ha: rott_c = 13'h073a;
            4'hb: rott_c = 13'h1bd0;
            4'hc: rott_c = 13'h09c4;
            default: rott_c = 13'h0000;
        endcase
    endfunction : rott_c

    // Curve exponent class
    function automatic rott_alpha_e rott_alpha(input logic [3:0] op);
        case (op)
            4'h3, 4'h5: rott_alpha = ROTT_A_ONE;
            4'h4, 4'h8, 4'h9, 4'hb, 4'hc: rott_alpha = ROTT_A_TWO;
            default: rott_alpha = ROTT_A_FRAC;
        endcase
    endfunction : rott_alpha

endpackage : rott_pkg

/* File: rtl/rott_trip_timer.sv */
/*
 * Residual overcurrent trip timer: threshold start, definite or inverse
 * time delay, general start and trip outputs, Wishbone register file.
 * Assumes the magnitude input is synchronous to clk and updated by an
 * upstream fundamental-component measurement stage.
 */

// Functional notes
// - Only the fundamental magnitude input is judged against settings.
// - Operation selects off, definite, or eleven inverse curves; off after reset.
// - Time multiplier 0.05 to 15 in 0.01 steps, default 1.0.
// - Minimum delay 40 to 60000 ms, default 100, inverse modes only.
// - Definite delay 40 to 60000 ms, default 100, definite mode only.
// - Inverse reset delay 60 to 60000 ms, default 100.
// - Internal start while picked up; internal trip when delay expires.
// - One block input disables the function while high.
// - General start and trip published from internal flags.
// - Inverse time is TMS times the sum of kr over ratio power minus one and c.
// - Above twenty times threshold the operate time stays flat.
// - Inverse trip needs curve time and minimum delay both expired.
// - Inverse curve surely operates above 1.1 times threshold.
module rott_trip_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Measurement and block input
    input wire logic [15:0] residual_fundamental_magnitude,
    input wire logic function_block_input,
    // Published outputs
    output logic general_start_out,
    output logic general_trip_out,
    output logic irq_o
);

    typedef struct packed {
        logic [3:0] op;
        logic [15:0] thr;
        logic [15:0] tms;
        logic [15:0] mindel;
        logic [15:0] defdel;
        logic [15:0] rstdel;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic ack;
        logic [31:0] dat;
        logic st_out;
        logic tr_out;
        logic irq;
        rott_pkg::rott_state_e fsm;
        logic [6:0] us_cnt;
        logic [9:0] ms_cnt;
        logic [55:0] acc;
        logic [23:0] ofs;
        logic [15:0] min_ms;
        logic [15:0] def_ms;
        logic [15:0] drop_ms;
    } rott_regs_s;

    rott_regs_s s_r;
    rott_regs_s s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge then clamp of a 16-bit setting
    function automatic logic [15:0] set16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel, input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic [15:0] v;
        v = old;
        if (sel[0]) begin
            v[7:0] = d[7:0];
        end
        if (sel[1]) begin
            v[15:8] = d[15:8];
        end
        if (v < lo) begin
            v = lo;
        end else if (v > hi) begin
            v = hi;
        end
        return v;
    endfunction : set16

    // Saturating millisecond count
    function automatic logic [15:0] inc16(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : inc16

    // Base-2 log, integer part and 8 fraction bits
    function automatic logic [11:0] lg2(input logic [15:0] x);
        logic [3:0] p;
        logic [15:0] m;
        p = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (x[i]) begin
                p = 4'(i);
            end
        end
        m = x << (4'hf - p);
        return {p, m[14:7]};
    endfunction : lg2

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    logic en;
    logic start;
    logic inv;
    logic tick;
    logic ms_tick;
    logic [15:0] gc;
    logic [15:0] gd;
    logic [31:0] d;
    logic [55:0] mul;
    logic [55:0] thr_acc;
    logic [23:0] ofs_end;
    logic wr;
    logic [1:0] ev;

    always_comb begin
        s_nxt = s_r;
        en = (s_r.op != rott_pkg::OP_OFF) && !function_block_input;
        inv = (s_r.op > rott_pkg::OP_DEF);
        start = en && (residual_fundamental_magnitude > s_r.thr);
        gd = 16'(s_r.thr * rott_pkg::GD_MULT);
        gc = (residual_fundamental_magnitude > gd) ? gd : residual_fundamental_magnitude;
        case (rott_pkg::rott_alpha(s_r.op))
            rott_pkg::ROTT_A_ONE: begin
                d = 32'(gc - s_r.thr);
                mul = 56'(s_r.thr);
            end
            rott_pkg::ROTT_A_TWO: begin
                d = 32'(gc) * 32'(gc) - 32'(s_r.thr) * 32'(s_r.thr);
                mul = 56'(32'(s_r.thr) * 32'(s_r.thr));
            end
            default: begin
                d = 32'(lg2(gc) - lg2(s_r.thr));
                mul = rott_pkg::LOG_K;
            end
        endcase
        thr_acc = 56'(s_r.tms) * 56'(rott_pkg::rott_kr(s_r.op)) * mul;
        ofs_end = 24'(s_r.tms) * 24'(rott_pkg::rott_c(s_r.op));

        // Time base
        tick = (s_r.us_cnt == 7'(rott_pkg::US_CYC - 1));
        ms_tick = tick && (s_r.ms_cnt == 10'(rott_pkg::MS_TICKS - 1));
        s_nxt.us_cnt = tick ? 7'h00 : s_r.us_cnt + 7'h01;
        if (tick) begin
            s_nxt.ms_cnt = ms_tick ? 10'h000 : s_r.ms_cnt + 10'h001;
        end

        // Delay state machine
        case (s_r.fsm)
            rott_pkg::ROTT_IDLE: begin
                if (start) begin
                    s_nxt.fsm = rott_pkg::ROTT_RUN;
                    s_nxt.acc = '0;
                    s_nxt.ofs = '0;
                    s_nxt.min_ms = '0;
                    s_nxt.def_ms = '0;
                    s_nxt.drop_ms = '0;
                end
            end
            rott_pkg::ROTT_RUN, rott_pkg::ROTT_OFFS: begin
                if (start) begin
                    s_nxt.drop_ms = '0;
                    if (ms_tick) begin
                        s_nxt.min_ms = inc16(s_r.min_ms);
                        s_nxt.def_ms = inc16(s_r.def_ms);
                    end
                    if (!inv) begin
                        if (s_r.def_ms >= s_r.defdel) begin
                            s_nxt.fsm = rott_pkg::ROTT_TRIP;
                        end
                    end else if (s_r.fsm == rott_pkg::ROTT_RUN) begin
                        if (tick) begin
                            s_nxt.acc = s_r.acc + 56'(d);
                        end
                        if (s_r.acc >= thr_acc) begin
                            s_nxt.fsm = rott_pkg::ROTT_OFFS;
                        end
                    end else begin
                        if (tick && s_r.ofs != 24'hffffff) begin
                            s_nxt.ofs = s_r.ofs + 24'h000001;
                        end
                        if (s_r.ofs >= ofs_end && s_r.min_ms >= s_r.mindel) begin
                            s_nxt.fsm = rott_pkg::ROTT_TRIP;
                        end
                    end
                end else if (!inv) begin
                    s_nxt.fsm = rott_pkg::ROTT_IDLE;
                end else begin
                    if (ms_tick) begin
                        s_nxt.drop_ms = inc16(s_r.drop_ms);
                    end
                    if (s_r.drop_ms >= s_r.rstdel) begin
                        s_nxt.fsm = rott_pkg::ROTT_IDLE;
                    end
                end
            end
            default: begin
                if (!start) begin
                    s_nxt.fsm = rott_pkg::ROTT_IDLE;
                end
            end
        endcase
        if (!en) begin
            s_nxt.fsm = rott_pkg::ROTT_IDLE;
        end

        s_nxt.st_out = start;
        s_nxt.tr_out = start && (s_r.fsm == rott_pkg::ROTT_TRIP);

        // Wishbone: ack one cycle after request, write at the acked edge
        s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
        s_nxt.dat = '0;
        if (wb_adr_i == rott_pkg::A_OPER) begin
            s_nxt.dat[3:0] = s_r.op;
        end else if (wb_adr_i == rott_pkg::A_THR) begin
            s_nxt.dat[15:0] = s_r.thr;
        end else if (wb_adr_i == rott_pkg::A_TMS) begin
            s_nxt.dat[15:0] = s_r.tms;
        end else if (wb_adr_i == rott_pkg::A_MINDEL) begin
            s_nxt.dat[15:0] = s_r.mindel;
        end else if (wb_adr_i == rott_pkg::A_DEFDEL) begin
            s_nxt.dat[15:0] = s_r.defdel;
        end else if (wb_adr_i == rott_pkg::A_RSTDEL) begin
            s_nxt.dat[15:0] = s_r.rstdel;
        end else if (wb_adr_i == rott_pkg::A_STAT) begin
            s_nxt.dat[3:0] = {s_r.fsm, s_r.tr_out, s_r.st_out};
        end else if (wb_adr_i == rott_pkg::A_IRQ_ST) begin
            s_nxt.dat[1:0] = s_r.irq_st;
        end else if (wb_adr_i == rott_pkg::A_IRQ_MASK) begin
            s_nxt.dat[1:0] = s_r.irq_mask;
        end

        // Register writes
        if (wr && wb_adr_i == rott_pkg::A_OPER && wb_sel_i[0]) begin
            s_nxt.op = (wb_dat_i[3:0] > rott_pkg::OP_LAST) ? rott_pkg::OP_OFF : wb_dat_i[3:0];
        end else if (wr && wb_adr_i == rott_pkg::A_THR) begin
            s_nxt.thr = set16(s_r.thr, wb_dat_i, wb_sel_i, rott_pkg::THR_MIN, rott_pkg::THR_MAX);
        end else if (wr && wb_adr_i == rott_pkg::A_TMS) begin
            s_nxt.tms = set16(s_r.tms, wb_dat_i, wb_sel_i, rott_pkg::TMS_MIN, rott_pkg::TMS_MAX);
        end else if (wr && wb_adr_i == rott_pkg::A_MINDEL) begin
            s_nxt.mindel = set16(s_r.mindel, wb_dat_i, wb_sel_i, rott_pkg::DLY_MIN,
                                 rott_pkg::DLY_MAX);
        end else if (wr && wb_adr_i == rott_pkg::A_DEFDEL) begin
            s_nxt.defdel = set16(s_r.defdel, wb_dat_i, wb_sel_i, rott_pkg::DLY_MIN,
                                 rott_pkg::DLY_MAX);
        end else if (wr && wb_adr_i == rott_pkg::A_RSTDEL) begin
            s_nxt.rstdel = set16(s_r.rstdel, wb_dat_i, wb_sel_i, rott_pkg::RDLY_MIN,
                                 rott_pkg::DLY_MAX);
        end else if (wr && wb_adr_i == rott_pkg::A_IRQ_MASK && wb_sel_i[0]) begin
            s_nxt.irq_mask = wb_dat_i[1:0];
        end

        // Sticky events, set wins over write-one clear
        ev = 2'b00;
        ev[rott_pkg::IRQ_START] = s_nxt.st_out && !s_r.st_out;
        ev[rott_pkg::IRQ_TRIP] = s_nxt.tr_out && !s_r.tr_out;
        s_nxt.irq_st = s_r.irq_st;
        if (wr && wb_adr_i == rott_pkg::A_IRQ_ST && wb_sel_i[0]) begin
            s_nxt.irq_st = s_r.irq_st & ~wb_dat_i[1:0];
        end
        s_nxt.irq_st = s_nxt.irq_st | ev;
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.op <= rott_pkg::OP_OFF;
            s_r.thr <= rott_pkg::THR_RST;
            s_r.tms <= rott_pkg::TMS_RST;
            s_r.mindel <= rott_pkg::DLY_RST;
            s_r.defdel <= rott_pkg::DLY_RST;
            s_r.rstdel <= rott_pkg::DLY_RST;
            s_r.fsm <= rott_pkg::ROTT_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign general_start_out = s_r.st_out;
    assign general_trip_out = s_r.tr_out;
    assign irq_o = s_r.irq;

endmodule : rott_trip_timer

/* File: testbench/rott_trip_timer_props.sv */
/*
 * Port checker of the residual overcurrent trip timer.
 * Assumes a bind onto rott_trip_timer and a 100 MHz clk.
 */
module rott_trip_timer_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Measurement and outputs
    input wire logic [15:0] residual_fundamental_magnitude,
    input wire logic function_block_input,
    input wire logic general_start_out,
    input wire logic general_trip_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TRIP_MIN_CYC = 3_900_000; // 40 ms less tick jitter
    logic [31:0] start_cyc_r;
    logic [31:0] start_cyc_nxt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Cycles since start rose
    always_comb begin
        start_cyc_nxt = general_start_out ? start_cyc_r + 32'h1 : 32'h0;
    end

    // Count register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_cyc_r <= 32'h0;
        end else begin
            start_cyc_r <= start_cyc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    AST_ACK_NEXT: assert property (s_taken |=> s_pulse) else $error("ack not one cycle after request");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    AST_BLK_START: assert property (function_block_input |=> !general_start_out) else $error("start while blocked");
    AST_BLK_TRIP: assert property (function_block_input |=> !general_trip_out) else $error("trip while blocked");
    AST_LOW_MAG: assert property (residual_fundamental_magnitude <= 16'h0005 |=> !general_start_out)
        else $error("start at magnitude below any threshold");
    AST_START_CAUSE: assert property ($rose(general_start_out) |->
        $past(residual_fundamental_magnitude) > 16'h0005 && !$past(function_block_input))
        else $error("start without cause");
    AST_TRIP_START: assert property ($rose(general_trip_out) |-> $past(general_start_out))
        else $error("trip without start");
    AST_TRIP_MIN: assert property (general_trip_out |-> start_cyc_r >= TRIP_MIN_CYC)
        else $error("trip before shortest delay");
endmodule : rott_trip_timer_chk

bind rott_trip_timer rott_trip_timer_chk chk_u (
    .clk(clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .residual_fundamental_magnitude(residual_fundamental_magnitude),
    .function_block_input(function_block_input),
    .general_start_out(general_start_out),
    .general_trip_out(general_trip_out)
);

/* File: testbench/rott_meas_model.sv */
/*
 * Upstream fundamental magnitude stage model.
 * Assumes the bench commands the level synchronous to clk.
 */
module rott_meas_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level wanted by the bench
    input wire logic [15:0] level_cmd,
    // Magnitude towards the block
    output logic [15:0] magnitude
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            magnitude <= 16'h0000;
        end else begin
            magnitude <= level_cmd;
        end
    end
endmodule : rott_meas_model

/* File: testbench/rott_trip_timer_test.sv */
/*
 * Self-checking bench of the residual overcurrent trip timer.
 * Assumes the checker bind and the magnitude model are compiled too.
 */
module rott_trip_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [15:0] level = 16'h0000;
    logic blk = 1'b0;
    logic [31:0] q;
    logic [31:0] rdat;
    logic ack;
    logic [15:0] mag;
    logic st;
    logic tr;
    logic irq;
    int n_mismatch = 0;
    int total_checks = 0;

    rott_meas_model meas_u (.clk(clk), .rst_n(rst_n), .level_cmd(level), .magnitude(mag));
    rott_trip_timer dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .residual_fundamental_magnitude(mag), .function_block_input(blk),
        .general_start_out(st), .general_trip_out(tr), .irq_o(irq));

    // Clock
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        cmp({31'h0, ack}, 32'h1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        cmp(q, exp);
    endtask : rd

    task automatic outs(input logic [15:0] lv, input logic es, input logic et);
        level <= lv;
        repeat (4) @(posedge clk);
        cmp({30'h0, tr, st}, {30'h0, et, es});
    endtask : outs

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(rott_pkg::A_OPER, 32'h0);
        rd(rott_pkg::A_THR, 32'h32);
        rd(rott_pkg::A_TMS, 32'h64);
        rd(rott_pkg::A_MINDEL, 32'h64);
        rd(rott_pkg::A_DEFDEL, 32'h64);
        rd(rott_pkg::A_RSTDEL, 32'h64);
        rd(8'h24, 32'h0);
        rd(rott_pkg::A_STAT, 32'h0);
        outs(16'h0100, 1'b0, 1'b0);
    endtask : t_reset

    task automatic t_clamp;
        wb(1'b1, rott_pkg::A_THR, 32'h1);
        rd(rott_pkg::A_THR, 32'h5);
        wb(1'b1, rott_pkg::A_THR, 32'hffff);
        rd(rott_pkg::A_THR, 32'h3e8);
        wb(1'b1, rott_pkg::A_THR, 32'h32);
        wb(1'b1, rott_pkg::A_TMS, 32'hffff);
        rd(rott_pkg::A_TMS, 32'h5dc);
        wb(1'b1, rott_pkg::A_TMS, 32'h4);
        rd(rott_pkg::A_TMS, 32'h5);
        wb(1'b1, rott_pkg::A_MINDEL, 32'h1);
        rd(rott_pkg::A_MINDEL, 32'h28);
        wb(1'b1, rott_pkg::A_DEFDEL, 32'hffff);
        rd(rott_pkg::A_DEFDEL, 32'hea60);
        wb(1'b1, rott_pkg::A_RSTDEL, 32'h1);
        rd(rott_pkg::A_RSTDEL, 32'h3c);
        wb(1'b1, rott_pkg::A_OPER, 32'hf);
        rd(rott_pkg::A_OPER, 32'h0);
        wb(1'b1, rott_pkg::A_DEFDEL, 32'h28);
        wb(1'b1, rott_pkg::A_TMS, 32'h64);
    endtask : t_clamp

    task automatic t_modes;
        for (int op = 1; op <= 12; op++) begin
            wb(1'b1, rott_pkg::A_OPER, 32'(op));
            outs(16'h0033, 1'b1, 1'b0);
            outs(16'h0032, 1'b0, 1'b0);
        end
    endtask : t_modes

    task automatic t_block;
        wb(1'b1, rott_pkg::A_OPER, 32'h1);
        outs(16'h0200, 1'b1, 1'b0);
        rd(rott_pkg::A_STAT, 32'({rott_pkg::ROTT_RUN, 2'b01}));
        blk <= 1'b1;
        outs(16'h0200, 1'b0, 1'b0);
        blk <= 1'b0;
        outs(16'h0200, 1'b1, 1'b0);
        repeat (20000) @(posedge clk);
        cmp({31'h0, tr}, 32'h0);
        wb(1'b1, rott_pkg::A_OPER, 32'h2);
        outs(16'h07d0, 1'b1, 1'b0);
        repeat (20000) @(posedge clk);
        cmp({31'h0, tr}, 32'h0);
    endtask : t_block

    task automatic t_irq;
        outs(16'h0000, 1'b0, 1'b0);
        wb(1'b1, rott_pkg::A_IRQ_ST, 32'h3);
        wb(1'b1, rott_pkg::A_IRQ_MASK, 32'h1);
        rd(rott_pkg::A_IRQ_MASK, 32'h1);
        outs(16'h0100, 1'b1, 1'b0);
        cmp({31'h0, irq}, 32'h1);
        rd(rott_pkg::A_IRQ_ST, 32'h1);
        wb(1'b1, rott_pkg::A_IRQ_ST, 32'h1);
        outs(16'h0000, 1'b0, 1'b0);
        cmp({31'h0, irq}, 32'h0);
        wb(1'b1, rott_pkg::A_IRQ_MASK, 32'h0);
        outs(16'h0100, 1'b1, 1'b0);
        cmp({31'h0, irq}, 32'h0);
        rd(rott_pkg::A_IRQ_ST, 32'h1);
    endtask : t_irq

    // Mid-run reset clears outputs and returns settings to reset values
    task automatic t_rerst;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        cmp({29'h0, irq, tr, st}, 32'h0);
        rst_n <= 1'b1;
        rd(rott_pkg::A_OPER, 32'h0);
        rd(rott_pkg::A_MINDEL, 32'h64);
        outs(16'h0100, 1'b0, 1'b0);
    endtask : t_rerst

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_clamp();
        t_modes();
        t_block();
        t_irq();
        t_rerst();
        conclude();
    end

    // Watchdog, about one and a half times the expected run
    initial begin
        #600us;
        n_mismatch++;
        conclude();
    end
endmodule : rott_trip_timer_test
